// ---- fpc_host.sv ----
// Purpose: Host controller driving a parallel flash's pins from APB orders
// Assumes: Flash inputs sampled synchronously; external buffers realise the
//          high-voltage level on the addr_bit_nine and output-gate pins from the hv enables
// Notes:   One operation at a time; CMD writes while busy are dropped
// Operation
// - Host reads flag before and after each extra erase command; high after means doubt.
// - Host starts a write with select and write strobe low, output gate high.
// - Protect: addr_bit_nine and output gate at high voltage, addr_bit_six low, select low, one strobe.
// - Unprotect: output gate and addr_bit_nine at high voltage, select low, addr_bit_six high, one strobe.
`timescale 1ns/1ps
module fpc_host #(
	parameter int ADDR_W     = 8,
	parameter int UNPROT_CYC = fpc_pkg::UNPROT_CYC
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_rst,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic [31:0]            o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	output logic [16:0]            o_addr,
	output logic                   o_ce_n,
	output logic                   o_oe_n,
	output logic                   o_we_n,
	output logic [7:0]             o_dq_out,
	output logic                   o_dq_oe,
	input  wire logic [7:0]        i_dq_in,
	output logic                   o_a9_hv,
	output logic                   o_oe_hv
);

	localparam int A_PROT_LEN = fpc_pkg::PROT_CYC;

	fpc_pkg::fpc_state_type state_q, state_d;
	logic [17:0] cnt_q, cnt_d;
	logic [2:0]  op_q, op_d;
	logic [1:0]  step_q, step_d;
	logic [16:0] addr_q, addr_d;
	logic [7:0]  wdata_q, wdata_d;
	logic [7:0]  rdata_q, rdata_d;
	logic [7:0]  first_q, first_d;
	logic        not_acc_q, not_acc_d;
	logic        flag_b4_q, flag_b4_d;
	logic        toggle_q, toggle_d;
	logic [16:0] pin_addr_q, pin_addr_d;
	logic        ce_n_q, ce_n_d;
	logic        oe_n_q, oe_n_d;
	logic        we_n_q, we_n_d;
	logic        dq_oe_q, dq_oe_d;
	logic        a9_hv_q, a9_hv_d;
	logic        oe_hv_q, oe_hv_d;
	logic        wr_en;
	logic        busy;
	logic        mapped;
	logic [1:0]  kind;
	logic [1:0]  new_kind;
	logic [17:0] act_len;

	// Pin phase kind for an opcode and step of the checked erase sequence
	function automatic logic [1:0] kind_of(input logic [2:0] op, input logic [1:0] step);
		logic [1:0] k;
		k = fpc_pkg::KIND_READ;
		case (op)
			fpc_pkg::OP_WRITE:     k = fpc_pkg::KIND_WRITE;
			fpc_pkg::OP_PROTECT:   k = fpc_pkg::KIND_PULSE;
			fpc_pkg::OP_UNPROTECT: k = fpc_pkg::KIND_PULSE;
			fpc_pkg::OP_VERIFY:    k = fpc_pkg::KIND_HVREAD;
			fpc_pkg::OP_ERASE_ADD: k = (step == 2'h1) ? fpc_pkg::KIND_WRITE : fpc_pkg::KIND_READ;
			default:               k = fpc_pkg::KIND_READ;
		endcase
		return k;
	endfunction : kind_of

	// APB decode; slave answers in its first access cycle
	assign busy     = (state_q != fpc_pkg::ST_IDLE);
	assign wr_en    = i_psel && i_penable && i_pwrite;
	assign mapped   = (i_paddr == fpc_pkg::REG_CMD) || (i_paddr == fpc_pkg::REG_ADDR) ||
	                  (i_paddr == fpc_pkg::REG_WDATA) || (i_paddr == fpc_pkg::REG_RDATA) ||
	                  (i_paddr == fpc_pkg::REG_STATUS);
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel && i_penable && !mapped;
	assign kind      = kind_of(op_q, step_q);
	assign new_kind  = kind_of(i_pwdata[2:0], 2'h0);

	// Read mux; unmapped addresses read as zero
	always_comb
	begin
		o_prdata = 32'h0;
		case (i_paddr)
			fpc_pkg::REG_ADDR:   o_prdata = {15'h0, addr_q};
			fpc_pkg::REG_WDATA:  o_prdata = {24'h0, wdata_q};
			fpc_pkg::REG_RDATA:  o_prdata = {24'h0, rdata_q};
			fpc_pkg::REG_STATUS: o_prdata = {28'h0, toggle_q, flag_b4_q, not_acc_q, busy};
			default:             o_prdata = 32'h0;
		endcase
	end

	// Length of the strobe phase; the unprotect pulse is the long one
	always_comb
	begin
		act_len = 18'(fpc_pkg::ACC_CYC);
		case (kind)
			fpc_pkg::KIND_WRITE: act_len = 18'(fpc_pkg::WE_CYC);
			fpc_pkg::KIND_PULSE: act_len = (op_q == fpc_pkg::OP_UNPROTECT) ? 18'(UNPROT_CYC)
			                                                             : 18'(fpc_pkg::PROT_CYC);
			default:             act_len = 18'(fpc_pkg::ACC_CYC);
		endcase
	end

	// Sequencer and pin next values
	always_comb
	begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		op_d       = op_q;
		step_d     = step_q;
		addr_d     = addr_q;
		wdata_d    = wdata_q;
		rdata_d    = rdata_q;
		first_d    = first_q;
		not_acc_d  = not_acc_q;
		flag_b4_d  = flag_b4_q;
		toggle_d   = toggle_q;
		pin_addr_d = pin_addr_q;
		ce_n_d     = 1'b1;
		oe_n_d     = 1'b1;
		we_n_d     = 1'b1;
		dq_oe_d    = 1'b0;
		a9_hv_d    = 1'b0;
		oe_hv_d    = 1'b0;
		// Address and data only change while idle so a running cycle stays stable
		if (wr_en && !busy && i_paddr == fpc_pkg::REG_ADDR)
			addr_d = i_pwdata[16:0];
		if (wr_en && !busy && i_paddr == fpc_pkg::REG_WDATA)
			wdata_d = i_pwdata[7:0];
		case (state_q)
			fpc_pkg::ST_IDLE:
			begin
				if (wr_en && i_paddr == fpc_pkg::REG_CMD && i_pwdata[2:0] <= fpc_pkg::OP_ERASE_ADD)
				begin
					op_d    = i_pwdata[2:0];
					step_d  = 2'h0;
					state_d = fpc_pkg::ST_SETUP;
					// High-voltage pins need the transition time before the strobe
					cnt_d   = (new_kind[1]) ? 18'(fpc_pkg::HV_CYC) : 18'(fpc_pkg::REC_CYC);
					if (i_pwdata[2:0] == fpc_pkg::OP_ERASE_ADD)
						not_acc_d = 1'b0;
				end
			end
			fpc_pkg::ST_SETUP:
			begin
				ce_n_d     = 1'b0;
				dq_oe_d    = (kind == fpc_pkg::KIND_WRITE);
				a9_hv_d    = kind[1];
				oe_hv_d    = (kind == fpc_pkg::KIND_PULSE);
				pin_addr_d = addr_q;
				if (op_q == fpc_pkg::OP_PROTECT)
					pin_addr_d[fpc_pkg::ADDR_BIT_SIX] = 1'b0;
				if (op_q == fpc_pkg::OP_UNPROTECT)
					pin_addr_d[fpc_pkg::ADDR_BIT_SIX] = 1'b1;
				cnt_d = cnt_q - 18'h1;
				if (cnt_q == 18'h1)
				begin
					state_d = fpc_pkg::ST_ACT;
					cnt_d   = act_len;
					// Write strobe low with output gate high starts a write cycle
					we_n_d  = !(kind == fpc_pkg::KIND_WRITE || kind == fpc_pkg::KIND_PULSE);
					oe_n_d  = !(kind == fpc_pkg::KIND_READ || kind == fpc_pkg::KIND_HVREAD);
				end
			end
			fpc_pkg::ST_ACT:
			begin
				ce_n_d  = 1'b0;
				dq_oe_d = (kind == fpc_pkg::KIND_WRITE);
				a9_hv_d = kind[1];
				oe_hv_d = (kind == fpc_pkg::KIND_PULSE);
				we_n_d  = we_n_q;
				oe_n_d  = oe_n_q;
				cnt_d   = cnt_q - 18'h1;
				if (cnt_q == 18'h1)
				begin
					state_d = fpc_pkg::ST_HOLD;
					cnt_d   = (kind[1]) ? 18'(fpc_pkg::HV_CYC) : 18'(fpc_pkg::REC_CYC);
					we_n_d  = 1'b1;
					oe_n_d  = 1'b1;
					// Hold the protect or unprotect pulse voltage and select on while the strobe rises
					a9_hv_d = (kind == fpc_pkg::KIND_PULSE);
					oe_hv_d = (kind == fpc_pkg::KIND_PULSE);
					if (!oe_n_q)
						rdata_d = i_dq_in;
					// Flag sampled before and after the extra erase command
					if (op_q == fpc_pkg::OP_ERASE_ADD && step_q == 2'h0)
					begin
						first_d   = i_dq_in;
						flag_b4_d = i_dq_in[fpc_pkg::ERASE_TIMER_FLAG];
					end
					if (op_q == fpc_pkg::OP_ERASE_ADD && step_q == fpc_pkg::STEP_LAST)
					begin
						not_acc_d = i_dq_in[fpc_pkg::ERASE_TIMER_FLAG];
						toggle_d  = i_dq_in[fpc_pkg::TOGGLE_STATUS_BIT] ^
						            first_q[fpc_pkg::TOGGLE_STATUS_BIT];
					end
				end
			end
			fpc_pkg::ST_HOLD:
			begin
				cnt_d = cnt_q - 18'h1;
				if (cnt_q == 18'h1)
				begin
					state_d = fpc_pkg::ST_IDLE;
					if (op_q == fpc_pkg::OP_ERASE_ADD && step_q != fpc_pkg::STEP_LAST)
					begin
						state_d = fpc_pkg::ST_SETUP;
						step_d  = step_q + 2'h1;
						cnt_d   = 18'(fpc_pkg::REC_CYC);
					end
				end
			end
			default:
			begin
				state_d = fpc_pkg::ST_IDLE;
			end
		endcase
	end

	// Registers; pins idle deselected with no high voltage
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q    <= fpc_pkg::ST_IDLE;
			cnt_q      <= 18'h0;
			op_q       <= fpc_pkg::OP_READ;
			step_q     <= 2'h0;
			addr_q     <= 17'h0;
			wdata_q    <= 8'h0;
			rdata_q    <= 8'h0;
			first_q    <= 8'h0;
			not_acc_q  <= 1'b0;
			flag_b4_q  <= 1'b0;
			toggle_q   <= 1'b0;
			pin_addr_q <= 17'h0;
			ce_n_q     <= 1'b1;
			oe_n_q     <= 1'b1;
			we_n_q     <= 1'b1;
			dq_oe_q    <= 1'b0;
			a9_hv_q    <= 1'b0;
			oe_hv_q    <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			op_q       <= op_d;
			step_q     <= step_d;
			addr_q     <= addr_d;
			wdata_q    <= wdata_d;
			rdata_q    <= rdata_d;
			first_q    <= first_d;
			not_acc_q  <= not_acc_d;
			flag_b4_q  <= flag_b4_d;
			toggle_q   <= toggle_d;
			pin_addr_q <= pin_addr_d;
			ce_n_q     <= ce_n_d;
			oe_n_q     <= oe_n_d;
			we_n_q     <= we_n_d;
			dq_oe_q    <= dq_oe_d;
			a9_hv_q    <= a9_hv_d;
			oe_hv_q    <= oe_hv_d;
		end
	end

	assign o_addr   = pin_addr_q;
	assign o_ce_n   = ce_n_q;
	assign o_oe_n   = oe_n_q;
	assign o_we_n   = we_n_q;
	assign o_dq_out = wdata_q;
	assign o_dq_oe  = dq_oe_q;
	assign o_a9_hv  = a9_hv_q;
	assign o_oe_hv  = oe_hv_q;

	// Normal write strobe only with select low and output gate high
	a_write_levels: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!o_we_n && !o_oe_hv) |-> (!o_ce_n && o_oe_n && o_dq_oe))
		else $error("write strobe without select low and output gate high");

	// Protect pulse carries the full high-voltage set-up
	a_protect_pins: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!o_we_n && op_q == fpc_pkg::OP_PROTECT) |->
		(o_a9_hv && o_oe_hv && !o_ce_n && !o_addr[fpc_pkg::ADDR_BIT_SIX]))
		else $error("protect pulse with wrong pin levels");

	// Unprotect pulse uses addr_bit_six high
	a_unprotect_pins: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!o_we_n && op_q == fpc_pkg::OP_UNPROTECT) |->
		(o_a9_hv && o_oe_hv && !o_ce_n && o_addr[fpc_pkg::ADDR_BIT_SIX]))
		else $error("unprotect pulse with wrong pin levels");

	// Protect pulse lasts exactly the programmed width
	a_protect_width: assert property (@(posedge i_core_clk) disable iff (i_rst)
		($fell(o_we_n) && op_q == fpc_pkg::OP_PROTECT) |-> ##A_PROT_LEN $rose(o_we_n))
		else $error("protect pulse width wrong");

	// Second flag read decides the doubt bit
	a_erase_verdict: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_q == fpc_pkg::ST_ACT && cnt_q == 18'h1 && op_q == fpc_pkg::OP_ERASE_ADD &&
		 step_q == fpc_pkg::STEP_LAST) |=> (not_acc_q == $past(i_dq_in[fpc_pkg::ERASE_TIMER_FLAG])))
		else $error("erase acceptance bit does not follow second flag read");

	// Checked erase reads, writes, reads: three select periods
	a_erase_steps: assert property (@(posedge i_core_clk) disable iff (i_rst)
		($fell(o_we_n) && op_q == fpc_pkg::OP_ERASE_ADD) |-> (step_q == 2'h1 && o_oe_n))
		else $error("erase command written outside its middle step");

endmodule : fpc_host

// ---- fpc_pkg.sv ----
// Purpose: Constants for the flash protect and erase host controller
// Assumes: 20 MHz core clock; flash pins driven by fpc_host
// Notes:   Register map, opcodes, pin bit positions and timing counts
package fpc_pkg;

	// APB register byte offsets
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// Command opcodes written to REG_CMD[2:0]
	localparam logic [2:0] OP_READ      = 3'h0;
	localparam logic [2:0] OP_WRITE     = 3'h1;
	localparam logic [2:0] OP_PROTECT   = 3'h2;
	localparam logic [2:0] OP_UNPROTECT = 3'h3;
	localparam logic [2:0] OP_VERIFY    = 3'h4;
	localparam logic [2:0] OP_ERASE_ADD = 3'h5;

	// Status register bit positions
	localparam int STAT_BUSY    = 0;
	localparam int STAT_NOT_ACC = 1;
	localparam int STAT_FLAG_B4 = 2;
	localparam int STAT_TOGGLE  = 3;

	// Flash data and address bit positions
	localparam int ERASE_TIMER_FLAG  = 3;
	localparam int TOGGLE_STATUS_BIT = 6;
	localparam int ADDR_BIT_SIX      = 6;

	// Pin phase kinds
	localparam logic [1:0] KIND_READ   = 2'h0;
	localparam logic [1:0] KIND_WRITE  = 2'h1;
	localparam logic [1:0] KIND_PULSE  = 2'h2;
	localparam logic [1:0] KIND_HVREAD = 2'h3;

	// Last step index of the checked sector erase sequence
	localparam logic [1:0] STEP_LAST = 2'h2;

	// Timing in printed units, then derived cycle counts
	localparam int CLK_NS      = 50;
	localparam int ACC_NS      = 120;
	localparam int WE_NS       = 50;
	localparam int REC_NS      = 20;
	localparam int HV_US       = 4;
	localparam int PROT_US     = 10;
	localparam int UNPROT_MS   = 12;
	localparam int ACC_CYC     = (ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_CYC      = (WE_NS + CLK_NS - 1) / CLK_NS;
	localparam int REC_CYC     = (REC_NS + CLK_NS - 1) / CLK_NS;
	localparam int HV_CYC      = (HV_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int PROT_CYC    = (PROT_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int UNPROT_CYC  = (UNPROT_MS * 1000000 + CLK_NS - 1) / CLK_NS;

	// Sequencer states, Gray along idle-setup-active-hold
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_SETUP = 2'h1,
		ST_ACT   = 2'h3,
		ST_HOLD  = 2'h2
	} fpc_state_type;

endpackage : fpc_pkg

// ---- fpc_flash_model.sv ----
// Purpose: Behavioural flash device facing fpc_host pins
// Assumes: Pins come straight from the host; high voltage shown by hv flags
// Notes:   Erase and identify commands are single writes; window and erase lengths are parameters
`timescale 1ns/1ps
module fpc_flash_model #(
	parameter int         WIN_NS    = 3000,
	parameter int         ERS_NS    = 4000,
	parameter int         GLITCH_NS = 5,
	parameter logic [7:0] ERASE_CMD = 8'h30,
	parameter logic [7:0] ID_CMD    = 8'h6E, // Arbitrary identify command code
	parameter logic [7:0] ID_CODE   = 8'h3C  // Arbitrary identity value
) (
	input  wire logic [16:0] i_addr,
	input  wire logic        i_ce_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic [7:0]  i_dq,
	input  wire logic        i_dq_oe,
	input  wire logic        i_a9_hv,
	input  wire logic        i_oe_hv,
	output logic [7:0]       o_dq
);
	logic       prot = 1'b0, win = 1'b0, ers = 1'b0, erased = 1'b0, tog = 1'b0; // Power-up in read mode
	logic [7:0] val, last = 8'h00;
	logic       id_mode = 1'b0;
	time        t_acc, t_ers, t_we;
	wire        rd_en = !i_ce_n && !i_oe_n;

	// Strobe fall time, to measure the pulse width
	always @(negedge i_we_n)
		t_we = $time;

	// Strobe rising edge ends a write or a protect pulse; short pulses are noise
	always @(posedge i_we_n)
		if ($time - t_we >= GLITCH_NS && !i_ce_n)
		begin
			if (i_a9_hv && i_oe_hv)
				prot = !i_addr[6];
			else if (i_oe_n && i_dq_oe && !ers)
			begin
				id_mode = (i_dq == ID_CMD); // Any other command leaves identify mode
				if (i_dq == ERASE_CMD && !prot)
				begin
					win = 1'b1; // Later erase commands restart the window
					t_acc = $time;
				end
			end
		end

	// Coarse time base for window expiry and erase completion
	initial forever #10
	begin
		if (win && $time - t_acc >= WIN_NS)
		begin
			win = 1'b0;
			ers = 1'b1;
			t_ers = $time;
		end
		if (ers && $time - t_ers >= ERS_NS)
		begin
			ers = 1'b0;
			erased = 1'b1;
		end
	end

	// Each read while busy flips the toggle bit
	always @(negedge i_oe_n)
		if (!i_ce_n && (win || ers))
			tog = !tog;

	// Read data source; released bus shows inverted last byte
	always @*
	begin
		if (i_a9_hv || id_mode)
			val = i_addr[1] ? {7'h00, prot} : ID_CODE;
		else if (win || ers)
			val = {1'b0, tog, 2'b00, ers, 3'b000};
		else
			val = erased ? 8'hFF : 8'hA5;
		if (rd_en)
			last = val;
	end
	assign o_dq = rd_en ? val : ~last;
endmodule : fpc_flash_model

// ---- testbench.sv ----
// Purpose: Self-checking bench for fpc_host with a flash model
// Assumes: APB slave answers with pready; unprotect pulse shortened
// Notes:   Expected bytes follow the flash rules kept by the model
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, ce_n, oe_n, we_n, dq_oe, a9_hv, oe_hv;
	logic [16:0] addr;
	logic [7:0]  dq_out, dq_in;
	int          fails = 0, check_count = 0, n;

	fpc_host #(.UNPROT_CYC(20)) fpc_host_inst (.i_core_clk(clk), .i_rst(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_addr(addr), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
		.o_dq_out(dq_out), .o_dq_oe(dq_oe), .i_dq_in(dq_in), .o_a9_hv(a9_hv), .o_oe_hv(oe_hv));
	fpc_flash_model fpc_flash_model_inst (.i_addr(addr), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_dq(dq_out), .i_dq_oe(dq_oe), .i_a9_hv(a9_hv), .i_oe_hv(oe_hv), .o_dq(dq_in));

	// 20 MHz clock
	always #25 clk = ~clk;

	task test_done;
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready under a bound
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50)
		begin
			fails++;
			test_done();
		end
	endtask : apb

	// Issue one command and wait until busy drops
	task op(input logic [2:0] c);
		apb(1'b1, fpc_pkg::REG_CMD, {29'h0, c});
		n = 0;
		do
		begin
			apb(1'b0, fpc_pkg::REG_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 2000);
		if (n >= 2000)
		begin
			fails++;
			test_done();
		end
	endtask : op

	task rdata(input logic [31:0] exp, input logic [31:0] st);
		chk(rd & 32'h0000000E, st);
		apb(1'b0, fpc_pkg::REG_RDATA, 32'h0);
		chk(rd, exp);
	endtask : rdata

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, fpc_pkg::REG_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, fpc_pkg::REG_ADDR, 32'h00100);
		op(fpc_pkg::OP_READ);
		rdata(32'hA5, 32'h0);
		apb(1'b1, fpc_pkg::REG_WDATA, 32'h11);
		op(fpc_pkg::OP_WRITE);
		op(fpc_pkg::OP_READ);
		rdata(32'hA5, 32'h0);
		// Verify reads: bit one selects status, rest ignored
		apb(1'b1, fpc_pkg::REG_ADDR, 32'h000F2);
		op(fpc_pkg::OP_VERIFY);
		rdata(32'h00, 32'h0);
		apb(1'b1, fpc_pkg::REG_ADDR, 32'h000F0);
		op(fpc_pkg::OP_VERIFY);
		rdata(32'h3C, 32'h0);
		op(fpc_pkg::OP_PROTECT);
		apb(1'b1, fpc_pkg::REG_ADDR, 32'h00002);
		op(fpc_pkg::OP_VERIFY);
		rdata(32'h01, 32'h0);
		// In-system identify read shows protection too; a plain write leaves that mode
		apb(1'b1, fpc_pkg::REG_WDATA, 32'h6E);
		op(fpc_pkg::OP_WRITE);
		op(fpc_pkg::OP_READ);
		rdata(32'h01, 32'h0);
		apb(1'b1, fpc_pkg::REG_WDATA, 32'h11);
		op(fpc_pkg::OP_WRITE);
		// Erase must be refused while protected
		apb(1'b1, fpc_pkg::REG_WDATA, 32'h30);
		apb(1'b1, fpc_pkg::REG_ADDR, 32'h00100);
		op(fpc_pkg::OP_ERASE_ADD);
		rdata(32'hA5, 32'h0);
		op(fpc_pkg::OP_UNPROTECT);
		apb(1'b1, fpc_pkg::REG_ADDR, 32'h00002);
		op(fpc_pkg::OP_VERIFY);
		rdata(32'h00, 32'h0);
		apb(1'b1, fpc_pkg::REG_ADDR, 32'h00100);
		op(fpc_pkg::OP_ERASE_ADD);
		rdata(32'h40, 32'h8);
		op(fpc_pkg::OP_ERASE_ADD);
		rdata(32'h40, 32'h8);
		repeat (80) @(posedge clk);
		op(fpc_pkg::OP_ERASE_ADD);
		rdata(32'h48, 32'hE);
		// Poll until the erase reports done
		n = 0;
		do
		begin
			op(fpc_pkg::OP_READ);
			apb(1'b0, fpc_pkg::REG_RDATA, 32'h0);
			n++;
		end while (rd[7] !== 1'b1 && n < 200);
		chk(rd, 32'hFF);
		test_done();
	end
endmodule : testbench
